// ---- acfs_pkg.sv ----
// constants, register map and types of the amplifier configuration and fault supervisor
package acfs_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned US_PER_S      = 1_000_000;
  localparam int unsigned CYC_PER_US    = CLK_HZ / US_PER_S;
  localparam logic [15:0] SAMPLE_US_RST = 16'd1000;
  localparam int unsigned NAXIS         = 4;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_SAMPLE  = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_FAULT0  = 8'h08;
  localparam logic [7:0] OFS_FAULT2  = 8'h0c;
  localparam logic [7:0] OFS_FAULT3  = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_CFG0    = 8'h20;
  localparam logic [7:0] OFS_CNT0    = 8'h30;
  // ==========================================================
  // axis config fields
  localparam int unsigned CFG_GAIN_LSB = 0;
  localparam int unsigned CFG_LOOP_LSB = 2;
  localparam int unsigned CFG_TYPE_LSB = 5;
  localparam int unsigned CFG_SEL_BIT  = 7;
  localparam int unsigned CFG_MAPV_LSB = 16;
  // command fields
  localparam int unsigned CMD_AXIS_LSB = 0;
  localparam int unsigned CMD_OP_LSB   = 2;
  // ==========================================================
  // amplifier gain codes and decoded milliamps per volt
  localparam logic [1:0]  GAIN_LO   = 2'h0;
  localparam logic [1:0]  GAIN_MID  = 2'h1;
  localparam logic [1:0]  GAIN_HI   = 2'h2;
  localparam logic [11:0] MAPV_LO   = 12'd400;
  localparam logic [11:0] MAPV_MID  = 12'd800;
  localparam logic [11:0] MAPV_HI   = 12'd1600;
  localparam logic [1:0]  GAIN_RST  = GAIN_MID;
  localparam logic [2:0]  LOOP_RST  = 3'h0;
  // motor command full scale 10 V = 32767, 5 V clamp
  localparam logic signed [15:0] CMD_LIM_5V = 16'sh4000;
  // ==========================================================
  typedef enum logic [1:0] {
    ACFS_BRUSHLESS = 2'h0,
    ACFS_BRUSHED   = 2'h1,
    ACFS_ILLEGAL   = 2'h2,
    ACFS_EXTERNAL  = 2'h3
  } acfs_mtype_e;

  typedef enum logic [2:0] {
    ACFS_OP_NONE   = 3'h0,
    ACFS_OP_ENABLE = 3'h1,
    ACFS_OP_DISABLE= 3'h2,
    ACFS_OP_LOCK   = 3'h3,
    ACFS_OP_SEARCH = 3'h4
  } acfs_op_e;
endpackage

// ---- acfs_sync.sv ----
// two-flop synchroniser for a group of fault flags
`timescale 1ns/1ps
`default_nettype none
module acfs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // flags
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } acfs_sync_s;

  acfs_sync_s st_q;
  acfs_sync_s st_d;

  // ==========================================================
  // stages
  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.s2;
endmodule
`default_nettype wire

// ---- acfs_axis.sv ----
// one axis: configuration, commutation setup tracking, enable and command clamp
`timescale 1ns/1ps
`default_nettype none
module acfs_axis (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  // register writes
  input  wire logic               cfg_we,
  input  wire logic [31:0]        wdata,
  input  wire logic               cnt_we,
  // commands
  input  wire logic               op_enable,
  input  wire logic               op_disable,
  input  wire logic               op_lock,
  input  wire logic               op_search,
  // supervision
  input  wire logic               kill,
  input  wire logic               power_ok,
  input  wire logic               servo_tick,
  // motor command path
  input  wire logic signed [15:0] cmd_in,
  output logic signed      [15:0] cmd_out,
  output logic                    amp_en,
  // state
  output logic             [31:0] cfg_rd,
  output logic             [15:0] counts_rd,
  output logic                    enabled,
  output logic                    comm_ready,
  output logic             [15:0] lock_travel,
  output logic                    lock_pulse
);
  typedef struct packed {
    logic [1:0]         gain;
    logic [2:0]         loop;
    logic [1:0]         mtype;
    logic               sel;
    logic [15:0]        counts;
    logic               phased;
    logic               en;
    logic signed [15:0] cmd;
    logic [15:0]        travel;
    logic               lock;
  } acfs_axis_s;

  acfs_axis_s st_q;
  acfs_axis_s st_d;
  logic [1:0] g_new;
  logic [1:0] t_new;
  logic       brless;
  logic       setup_ok;

  assign g_new    = wdata[acfs_pkg::CFG_GAIN_LSB +: 2];
  assign t_new    = wdata[acfs_pkg::CFG_TYPE_LSB +: 2];
  assign brless   = (st_q.mtype == acfs_pkg::ACFS_BRUSHLESS);
  assign setup_ok = st_q.sel && (st_q.counts != 16'h0000) && st_q.phased;

  // ==========================================================
  // next state
  always_comb begin
    st_d      = st_q;
    st_d.lock = 1'b0;
    if (cfg_we) begin
      if (!st_q.en && g_new != 2'h3) begin
        st_d.gain = g_new;
      end
      if (!st_q.en) begin
        st_d.loop = wdata[acfs_pkg::CFG_LOOP_LSB +: 3];
      end
      if (t_new != acfs_pkg::ACFS_ILLEGAL && t_new != st_q.mtype && !st_q.en) begin
        st_d.mtype  = t_new;
        st_d.phased = 1'b0;
        st_d.sel    = 1'b0;
      end else if (brless) begin
        st_d.sel = wdata[acfs_pkg::CFG_SEL_BIT];
      end
    end
    if (cnt_we && brless) begin
      st_d.counts = wdata[15:0];
      st_d.phased = 1'b0;
    end
    if ((op_lock || op_search) && brless && st_q.sel && st_q.counts != 16'h0000) begin
      st_d.phased = 1'b1;
      if (op_lock) begin
        st_d.lock   = 1'b1;
        st_d.travel = {1'b0, st_q.counts[15:1]};
      end
    end
    if (op_enable && !kill && (!brless || setup_ok)) begin
      st_d.en = 1'b1;
    end
    if (op_disable || kill) begin
      st_d.en = 1'b0;
    end
    if (servo_tick) begin
      if (!(st_q.en && power_ok)) begin
        st_d.cmd = 16'sh0000;
      end else if (st_q.gain == acfs_pkg::GAIN_HI && cmd_in > acfs_pkg::CMD_LIM_5V) begin
        st_d.cmd = acfs_pkg::CMD_LIM_5V;
      end else if (st_q.gain == acfs_pkg::GAIN_HI && cmd_in < -acfs_pkg::CMD_LIM_5V) begin
        st_d.cmd = -acfs_pkg::CMD_LIM_5V;
      end else begin
        st_d.cmd = cmd_in;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q      <= '0;
      st_q.gain <= acfs_pkg::GAIN_RST;
      st_q.loop <= acfs_pkg::LOOP_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  logic [11:0] mapv;
  always_comb begin
    unique case (st_q.gain)
      acfs_pkg::GAIN_LO:  mapv = acfs_pkg::MAPV_LO;
      acfs_pkg::GAIN_MID: mapv = acfs_pkg::MAPV_MID;
      acfs_pkg::GAIN_HI:  mapv = acfs_pkg::MAPV_HI;
      default:            mapv = 12'h000;
    endcase
  end

  assign cfg_rd      = {4'h0, mapv, 8'h00, st_q.sel, st_q.mtype, st_q.loop, st_q.gain};
  assign counts_rd   = st_q.counts;
  assign enabled     = st_q.en;
  assign comm_ready  = setup_ok;
  assign amp_en      = st_q.en && power_ok && !kill;
  assign cmd_out     = st_q.cmd;
  assign lock_travel = st_q.travel;
  assign lock_pulse  = st_q.lock;
endmodule
`default_nettype wire

// ---- acfs_top.sv ----
// amplifier configuration and fault supervisor: bus slave, sample timer, fault latches
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - sample period in microseconds, resets to 1000, software may lower it.
// - brushless enable needs axis select, counts per cycle, then lock or search.
// - phase lock forces a known phase, moving up to half a cycle.
// - gain code 0,1,2 decode to 0.4, 0.8, 1.6 amps per volt.
// - gain writes take effect only while the axis is disabled.
// - gain code 2 clamps motor command to 5 volts.
// - motor type 1 is brushed; commutation setup is not used there.
// - motor type -1 is external drive; enable needs no commutation setup.
// - cut-off input disables all axes, sets group 3, calls handler.
// - fault query gives eight bits for groups 0, 2 and 3.
// - fault query reads have no side effect.
// - detected error jumps to handler when thread zero runs with label.
// - below 18 volts amplifier off, resumes by itself above.
// - supply absent at power-up with handler present calls handler.
// - over 94 volts off, on below 90; not latched, no handler.
// - pair over 20 amps latches off until clear plus enable or reset.
// - over 80 degrees latches off, calls handler, clears by enable when cool.
module acfs_top (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  // avalon-mm slave
  input  wire logic [7:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  // fault sensing flags
  input  wire logic                   supply_under_18v,
  input  wire logic                   supply_over_94v,
  input  wire logic                   supply_under_90v,
  input  wire logic [1:0]             pair_over_20a,
  input  wire logic                   heatsink_over_80c,
  input  wire logic [3:0]             axis_over_cont,
  input  wire logic                   emergency_power_cutoff,
  // program sequencer
  input  wire logic                   thread0_running,
  input  wire logic                   handler_label_present,
  output logic                        amp_error_jump,
  // servo timing
  output logic                        servo_tick,
  // per-axis drive
  input  wire logic signed [4*16-1:0] motor_cmd_in,
  output logic signed      [4*16-1:0] motor_cmd_out,
  output logic             [3:0]      amp_enable,
  output logic             [3:0]      phase_lock_pulse,
  output logic             [4*16-1:0] phase_lock_travel
);
  localparam int NA = acfs_pkg::NAXIS;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [15:0] sample_us;
    logic [7:0]  cyc_cnt;
    logic [15:0] us_cnt;
    logic        tick;
    logic        ov_act;
    logic [1:0]  oc_lat;
    logic        ot_lat;
    logic        elo_lat;
    logic        err_prev;
    logic        jump;
  } acfs_top_s;

  acfs_top_s st_q;
  acfs_top_s st_d;

  // ==========================================================
  // synchronised fault flags
  logic       s_uv;
  logic       s_ovh;
  logic       s_ovl;
  logic [1:0] s_oc;
  logic       s_ot;
  logic [3:0] s_cont;
  logic       s_elo;

  acfs_sync #(
    .W(11)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in ({supply_under_18v, supply_over_94v, supply_under_90v, pair_over_20a,
                heatsink_over_80c, axis_over_cont, emergency_power_cutoff}),
    .sync_out ({s_uv, s_ovh, s_ovl, s_oc, s_ot, s_cont, s_elo})
  );

  // ==========================================================
  // bus decode
  logic        req;
  logic        wr_go;
  logic [7:0]  wofs;
  logic [31:0] wmask;
  logic [31:0] sample_merged;
  logic [1:0]  cmd_axis;
  logic [2:0]  cmd_op;
  logic [NA-1:0] ax_cfg_we;
  logic [NA-1:0] ax_cnt_we;
  logic [NA-1:0] ax_en_op;
  logic [NA-1:0] ax_dis_op;
  logic [NA-1:0] ax_lock_op;
  logic [NA-1:0] ax_srch_op;
  logic [NA-1:0] ax_kill;
  logic [NA-1:0] ax_enabled;
  logic [NA-1:0] ax_ready;
  logic [31:0]   ax_cfg_rd [NA];
  logic [15:0]   ax_cnt_rd [NA];
  logic          power_ok;
  logic [7:0]    fault_g0;
  logic [7:0]    fault_g2;
  logic [7:0]    fault_g3;

  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !st_q.ack;
  assign wr_go           = avs_write && st_q.ack;
  assign wofs            = {avs_address[7:2], 2'b00};
  assign cmd_axis        = avs_writedata[acfs_pkg::CMD_AXIS_LSB +: 2];
  assign cmd_op          = avs_writedata[acfs_pkg::CMD_OP_LSB +: 3];

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
    end
  end

  assign sample_merged = ({16'h0000, st_q.sample_us} & ~wmask) | (avs_writedata & wmask);

  always_comb begin
    for (int a = 0; a < NA; a++) begin
      ax_cfg_we[a]  = wr_go && wofs == acfs_pkg::OFS_CFG0 + 8'(4 * a);
      ax_cnt_we[a]  = wr_go && wofs == acfs_pkg::OFS_CNT0 + 8'(4 * a);
      ax_en_op[a]   = wr_go && wofs == acfs_pkg::OFS_COMMAND && cmd_axis == 2'(a)
                      && cmd_op == acfs_pkg::ACFS_OP_ENABLE;
      ax_dis_op[a]  = wr_go && wofs == acfs_pkg::OFS_COMMAND && cmd_axis == 2'(a)
                      && cmd_op == acfs_pkg::ACFS_OP_DISABLE;
      ax_lock_op[a] = wr_go && wofs == acfs_pkg::OFS_COMMAND && cmd_axis == 2'(a)
                      && cmd_op == acfs_pkg::ACFS_OP_LOCK;
      ax_srch_op[a] = wr_go && wofs == acfs_pkg::OFS_COMMAND && cmd_axis == 2'(a)
                      && cmd_op == acfs_pkg::ACFS_OP_SEARCH;
    end
  end

  // ==========================================================
  // fault query bytes, read only
  assign fault_g0 = {3'b000, st_q.ot_lat, st_q.oc_lat, st_q.ov_act, s_uv};
  assign fault_g2 = {4'h0, s_cont};
  assign fault_g3 = {7'h00, st_q.elo_lat};
  assign power_ok = !s_uv && !st_q.ov_act;

  // ==========================================================
  // next state
  logic       any_en_op;
  logic [1:0] pair_en_op;

  assign any_en_op  = |ax_en_op;
  assign pair_en_op = {ax_en_op[3] || ax_en_op[2], ax_en_op[1] || ax_en_op[0]};

  always_comb begin
    st_d      = st_q;
    st_d.ack  = req && !st_q.ack;
    st_d.tick = 1'b0;
    // read data captured while waitrequest is high; no read clears anything
    if (req && !st_q.ack) begin
      st_d.rdata = 32'h0000_0000;
      if (wofs == acfs_pkg::OFS_SAMPLE) begin
        st_d.rdata = {16'h0000, st_q.sample_us};
      end else if (wofs == acfs_pkg::OFS_FAULT0) begin
        st_d.rdata = {24'h000000, fault_g0};
      end else if (wofs == acfs_pkg::OFS_FAULT2) begin
        st_d.rdata = {24'h000000, fault_g2};
      end else if (wofs == acfs_pkg::OFS_FAULT3) begin
        st_d.rdata = {24'h000000, fault_g3};
      end else if (wofs == acfs_pkg::OFS_STATUS) begin
        st_d.rdata = {23'h000000, power_ok, ax_ready, ax_enabled};
      end
      for (int a = 0; a < NA; a++) begin
        if (wofs == acfs_pkg::OFS_CFG0 + 8'(4 * a)) begin
          st_d.rdata = ax_cfg_rd[a];
        end
        if (wofs == acfs_pkg::OFS_CNT0 + 8'(4 * a)) begin
          st_d.rdata = {16'h0000, ax_cnt_rd[a]};
        end
      end
    end
    if (wr_go && wofs == acfs_pkg::OFS_SAMPLE) begin
      st_d.sample_us = sample_merged[15:0];
    end
    // microsecond prescaler and sample period divider
    if (st_q.cyc_cnt == 8'(acfs_pkg::CYC_PER_US - 1)) begin
      st_d.cyc_cnt = 8'h00;
      if (st_q.us_cnt + 16'h0001 >= st_q.sample_us) begin
        st_d.us_cnt = 16'h0000;
        st_d.tick   = 1'b1;
      end else begin
        st_d.us_cnt = st_q.us_cnt + 16'h0001;
      end
    end else begin
      st_d.cyc_cnt = st_q.cyc_cnt + 8'h01;
    end
    // over-voltage hysteresis, not latched
    if (s_ovh) begin
      st_d.ov_act = 1'b1;
    end else if (s_ovl) begin
      st_d.ov_act = 1'b0;
    end
    // latched faults: set wins over an enable that would clear
    for (int p = 0; p < 2; p++) begin
      if (s_oc[p]) begin
        st_d.oc_lat[p] = 1'b1;
      end else if (pair_en_op[p]) begin
        st_d.oc_lat[p] = 1'b0;
      end
    end
    if (s_ot) begin
      st_d.ot_lat = 1'b1;
    end else if (any_en_op) begin
      st_d.ot_lat = 1'b0;
    end
    if (s_elo) begin
      st_d.elo_lat = 1'b1;
    end else if (any_en_op) begin
      st_d.elo_lat = 1'b0;
    end
    // handler call on a newly detected error; err_prev resets low so an
    // absent supply at power-up is seen as a new error
    st_d.err_prev = s_uv || (|st_d.oc_lat) || st_d.ot_lat || st_d.elo_lat;
    st_d.jump     = st_d.err_prev && !st_q.err_prev && thread0_running && handler_label_present;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q           <= '0;
      st_q.sample_us <= acfs_pkg::SAMPLE_US_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // axes
  generate
    for (genvar a = 0; a < NA; a++) begin : g_axis
      assign ax_kill[a] = st_d.elo_lat || st_d.ot_lat || st_d.oc_lat[a/2];

      acfs_axis u_axis (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .cfg_we      (ax_cfg_we[a]),
        .wdata       (avs_writedata),
        .cnt_we      (ax_cnt_we[a]),
        .op_enable   (ax_en_op[a]),
        .op_disable  (ax_dis_op[a]),
        .op_lock     (ax_lock_op[a]),
        .op_search   (ax_srch_op[a]),
        .kill        (ax_kill[a]),
        .power_ok    (power_ok),
        .servo_tick  (st_q.tick),
        .cmd_in      (motor_cmd_in[a*16 +: 16]),
        .cmd_out     (motor_cmd_out[a*16 +: 16]),
        .amp_en      (amp_enable[a]),
        .cfg_rd      (ax_cfg_rd[a]),
        .counts_rd   (ax_cnt_rd[a]),
        .enabled     (ax_enabled[a]),
        .comm_ready  (ax_ready[a]),
        .lock_travel (phase_lock_travel[a*16 +: 16]),
        .lock_pulse  (phase_lock_pulse[a])
      );
    end
  endgenerate

  // ==========================================================
  // outputs
  assign avs_readdata   = st_q.rdata;
  assign amp_error_jump = st_q.jump;
  assign servo_tick     = st_q.tick;
endmodule
`default_nettype wire

// ---- acfs_assertions.sv ----
// concurrent checks on the ports of the amplifier configuration and fault supervisor
`timescale 1ns/1ps
`default_nettype none
module acfs_assertions (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rstn,
  // bus
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  // fault flags
  input wire logic       supply_under_18v,
  input wire logic       supply_over_94v,
  input wire logic [1:0] pair_over_20a,
  input wire logic       heatsink_over_80c,
  input wire logic       emergency_power_cutoff,
  // sequencer and outputs
  input wire logic       thread0_running,
  input wire logic       handler_label_present,
  input wire logic       amp_error_jump,
  input wire logic       servo_tick,
  input wire logic [3:0] amp_enable
);
  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("request not stalled in its first cycle");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");
  a_tick_single: assert property (servo_tick |=> !servo_tick)
    else $error("servo tick longer than one cycle");
  a_jump_single: assert property (amp_error_jump |=> !amp_error_jump)
    else $error("handler jump longer than one cycle");
  a_jump_gated: assert property (amp_error_jump |-> $past(thread0_running) && $past(handler_label_present))
    else $error("handler jump without running thread and label");
  a_cutoff_off: assert property (emergency_power_cutoff [*4] |-> amp_enable == 4'h0)
    else $error("amplifier on during cut-off");
  a_uv_off: assert property (supply_under_18v [*4] |-> amp_enable == 4'h0)
    else $error("amplifier on under low supply");
  a_ov_off: assert property (supply_over_94v [*4] |-> amp_enable == 4'h0)
    else $error("amplifier on under high supply");
  a_ot_off: assert property (heatsink_over_80c [*4] |-> amp_enable == 4'h0)
    else $error("amplifier on while heat sink hot");
  a_oc_pair: assert property (pair_over_20a[0] [*4] |-> amp_enable[1:0] == 2'h0)
    else $error("first pair on during over-current");
endmodule
bind acfs_top acfs_assertions acfs_assertions_inst (.sys_clk, .rstn, .avs_read, .avs_write, .avs_waitrequest,
  .supply_under_18v, .supply_over_94v, .pair_over_20a, .heatsink_over_80c, .emergency_power_cutoff,
  .thread0_running, .handler_label_present, .amp_error_jump, .servo_tick, .amp_enable);
`default_nettype wire

// ---- acfs_sensor_model.sv ----
// fault sensing model: supply, pair current and heat sink comparators
`timescale 1ns/1ps
`default_nettype none
module acfs_sensor_model (
  // quantities in volts, degrees and amps
  input  wire logic [7:0]  supply_v,
  input  wire logic [7:0]  temp_c,
  input  wire logic [15:0] pair_amps,
  // comparator flags
  output logic             under_18v,
  output logic             over_94v,
  output logic             under_90v,
  output logic [1:0]       over_20a,
  output logic             over_80c
);
  // ==========================================================
  // comparators
  assign under_18v   = supply_v < 8'd18;
  assign over_94v    = supply_v > 8'd94;
  assign under_90v   = supply_v < 8'd90;
  assign over_20a[0] = pair_amps[7:0] > 8'd20;
  assign over_20a[1] = pair_amps[15:8] > 8'd20;
  assign over_80c    = temp_c > 8'd80;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// testbench of the amplifier configuration and fault supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================
  // signals
  logic               sys_clk = 1'b0;
  logic               rstn = 1'b0;
  logic [7:0]         avs_address = 8'h00;
  logic               avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0]        avs_writedata = 32'h0;
  logic [31:0]        avs_readdata, rd;
  logic               avs_waitrequest, u18, o94, u90, o80, jump, tick;
  logic [1:0]         o20;
  logic [3:0]         over_cont = 4'h0;
  logic               cutoff = 1'b0, thr0 = 1'b1;
  logic signed [63:0] cmd_in = 64'sh0, cmd_out;
  logic [3:0]         amp_en, lock_p;
  logic [63:0]        travel;
  logic [7:0]         supply_v = 8'd48, temp_c = 8'd25;
  logic [15:0]        pair_amps = 16'h0;
  int                 bad_count = 0, check_count = 0;
  int                 jumps = 0, locks = 0, cycles = 0, n;
  always #2.5 sys_clk = ~sys_clk;
  // ==========================================================
  // instances
  acfs_sensor_model acfs_sensor_model_inst (.supply_v(supply_v), .temp_c(temp_c), .pair_amps(pair_amps),
    .under_18v(u18), .over_94v(o94), .under_90v(u90), .over_20a(o20), .over_80c(o80));
  acfs_top acfs_top_inst (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .supply_under_18v(u18), .supply_over_94v(o94), .supply_under_90v(u90),
    .pair_over_20a(o20), .heatsink_over_80c(o80), .axis_over_cont(over_cont), .emergency_power_cutoff(cutoff),
    .thread0_running(thr0), .handler_label_present(1'b1), .amp_error_jump(jump), .servo_tick(tick),
    .motor_cmd_in(cmd_in), .motor_cmd_out(cmd_out), .amp_enable(amp_en), .phase_lock_pulse(lock_p),
    .phase_lock_travel(travel));
  // ==========================================================
  // tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 50) bad_count++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic cmd(input logic [1:0] ax, input acfs_pkg::acfs_op_e op);
    bus(1'b1, acfs_pkg::OFS_COMMAND, {27'h0, op, ax});
  endtask
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(posedge sys_clk);
      c++;
    end while (tick !== 1'b1 && c < 2000);
  endtask
  task automatic settle();
    repeat (8) @(posedge sys_clk);
  endtask
  // ==========================================================
  // counters and timeout
  always @(negedge sys_clk) begin
    cycles++;
    if (jump === 1'b1) jumps++;
    if (lock_p[0] === 1'b1) locks++;
    if (cycles == 30000) begin
      bad_count++;
      conclude();
    end
  end
  // ==========================================================
  // sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rdchk(acfs_pkg::OFS_SAMPLE, 32'd1000);
    bus(1'b1, acfs_pkg::OFS_SAMPLE, 32'd2);
    rdchk(acfs_pkg::OFS_CFG0, 32'h0320_0001);
    rdchk(8'hfc, 32'h0);
    rdchk(acfs_pkg::OFS_FAULT0, 32'h0);
    wait_tick(n);
    wait_tick(n);
    chk(n, 32'd400);
    for (int g = 0; g < 3; g++) begin
      bus(1'b1, acfs_pkg::OFS_CFG0, g);
      rdchk(acfs_pkg::OFS_CFG0, {4'h0, 12'd400 << g, 14'h0, 2'(g)});
    end
    cmd(2'd0, acfs_pkg::ACFS_OP_ENABLE);
    bus(1'b0, acfs_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h11f, 32'h100);
    bus(1'b1, acfs_pkg::OFS_CFG0, 32'h86);
    bus(1'b1, acfs_pkg::OFS_CNT0, 32'd100);
    cmd(2'd0, acfs_pkg::ACFS_OP_LOCK);
    chk({16'h0, travel[15:0]}, 32'd50);
    chk(locks, 32'd1);
    cmd(2'd0, acfs_pkg::ACFS_OP_ENABLE);
    bus(1'b0, acfs_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h11f, 32'h111);
    bus(1'b1, acfs_pkg::OFS_CFG0, 32'h80);
    rdchk(acfs_pkg::OFS_CFG0, 32'h0640_0086);
    cmd_in <= 64'sh7000;
    wait_tick(n);
    wait_tick(n);
    chk({16'h0, cmd_out[15:0]}, 32'h4000);
    bus(1'b1, 8'h24, 32'h20);
    cmd(2'd1, acfs_pkg::ACFS_OP_ENABLE);
    bus(1'b1, 8'h28, 32'h60);
    cmd(2'd2, acfs_pkg::ACFS_OP_ENABLE);
    cmd(2'd3, acfs_pkg::ACFS_OP_ENABLE);
    chk({28'h0, amp_en}, 32'h7);
    // over-temperature latch and handler
    temp_c <= 8'd90;
    settle();
    chk({28'h0, amp_en}, 32'h0);
    rdchk(acfs_pkg::OFS_FAULT0, 32'h10);
    rdchk(acfs_pkg::OFS_FAULT0, 32'h10);
    chk(jumps, 32'd1);
    temp_c <= 8'd25;
    settle();
    chk({31'h0, amp_en[0]}, 32'h0);
    cmd(2'd0, acfs_pkg::ACFS_OP_ENABLE);
    chk({31'h0, amp_en[0]}, 32'h1);
    // over-voltage with hysteresis
    supply_v <= 8'd95;
    settle();
    chk({28'h0, amp_en}, 32'h0);
    rdchk(acfs_pkg::OFS_FAULT0, 32'h2);
    supply_v <= 8'd92;
    settle();
    chk({31'h0, amp_en[0]}, 32'h0);
    supply_v <= 8'd85;
    settle();
    chk({31'h0, amp_en[0]}, 32'h1);
    chk(jumps, 32'd1);
    // under-voltage
    supply_v <= 8'd15;
    settle();
    chk({28'h0, amp_en}, 32'h0);
    rdchk(acfs_pkg::OFS_FAULT0, 32'h1);
    supply_v <= 8'd48;
    settle();
    chk({31'h0, amp_en[0]}, 32'h1);
    chk(jumps, 32'd2);
    // over-current on first pair
    pair_amps <= 16'd25;
    settle();
    chk({30'h0, amp_en[1:0]}, 32'h0);
    rdchk(acfs_pkg::OFS_FAULT0, 32'h4);
    pair_amps <= 16'd0;
    settle();
    chk({31'h0, amp_en[0]}, 32'h0);
    cmd(2'd0, acfs_pkg::ACFS_OP_ENABLE);
    chk({31'h0, amp_en[0]}, 32'h1);
    chk(jumps, 32'd3);
    over_cont <= 4'ha;
    settle();
    rdchk(acfs_pkg::OFS_FAULT2, 32'ha);
    // emergency cut-off and recovery
    cutoff <= 1'b1;
    settle();
    chk({28'h0, amp_en}, 32'h0);
    rdchk(acfs_pkg::OFS_FAULT3, 32'h1);
    bus(1'b0, acfs_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'hf, 32'h0);
    chk(jumps, 32'd4);
    cutoff <= 1'b0;
    cmd(2'd0, acfs_pkg::ACFS_OP_DISABLE);
    repeat (2) @(posedge sys_clk);
    cmd(2'd0, acfs_pkg::ACFS_OP_ENABLE);
    chk({31'h0, amp_en[0]}, 32'h1);
    rdchk(acfs_pkg::OFS_FAULT3, 32'h0);
    thr0 <= 1'b0;
    supply_v <= 8'd15;
    settle();
    chk(jumps, 32'd4);
    thr0 <= 1'b1;
    rstn <= 1'b0;
    settle();
    rstn <= 1'b1;
    settle();
    chk(jumps, 32'd5);
    rdchk(acfs_pkg::OFS_SAMPLE, 32'd1000);
    conclude();
  end
endmodule
`default_nettype wire
